// file: pm_cfg.svh
// register map, field positions and arithmetic constants of the monitor
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// register offsets on the host register port
`define PM_OFS_BUS      8'h02
`define PM_OFS_PWR      8'h03
`define PM_OFS_CUR      8'h04
`define PM_OFS_CAL      8'h05
`define PM_OFS_MASK     8'h06
`define PM_OFS_LIMIT    8'h07

// reset values
`define PM_RST_WORD     16'h0000

// alarm select and flags fields
`define PM_B_SHUNT_OVER 15
`define PM_B_SHUNT_UNDR 14
`define PM_B_BUS_OVER   13
`define PM_B_BUS_UNDR   12
`define PM_B_PWR_OVER   11
`define PM_B_DONE_ALARM 10
`define PM_B_LIMIT_FLAG 4
`define PM_B_DONE_FLAG  3
`define PM_B_OVF_FLAG   2
`define PM_B_LVL_INV    1
`define PM_B_HOLD_EN    0

// scaling: current = shunt * calib >> shift, power = current * bus / div
`define PM_CURRENT_SHIFT 11
`define PM_POWER_LSB_RATIO 25
`define PM_BUS_LSB_UV   1250
`define PM_POWER_DIV    (1000000 / `PM_BUS_LSB_UV * `PM_POWER_LSB_RATIO)

// index of the last divider iteration; 31 iterations, one per dividend bit
`define PM_DIV_STEPS    5'd30

`endif

// file: pm_divider.sv
// sequential restoring divider for the power scaling step
`timescale 1ns/100ps
`default_nettype none
`include "pm_cfg.svh"

module pm_divider
    import pm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [30:0] dividend,
    input  wire logic [14:0] divisor,
    output logic             done,
    output logic [30:0]      quotient
);

    pm_div_t d_reg;
    pm_div_t d_next;
    logic [15:0] trial;

    // one quotient bit per cycle, dividend shifted in from the top
    always_comb begin
        d_next = d_reg;
        d_next.done = 1'b0;
        trial = {d_reg.rem[14:0], d_reg.quo[30]};
        if (abort) begin
            d_next.busy = 1'b0;
        end else if (start) begin
            d_next.busy = 1'b1;
            d_next.cnt  = 5'd0;
            d_next.rem  = 16'h0000;
            d_next.quo  = dividend;
        end else if (d_reg.busy) begin
            if (trial >= {1'b0, divisor}) begin
                d_next.rem = trial - {1'b0, divisor};
                d_next.quo = {d_reg.quo[29:0], 1'b1};
            end else begin
                d_next.rem = trial;
                d_next.quo = {d_reg.quo[29:0], 1'b0};
            end
            d_next.cnt = d_reg.cnt + 5'd1;
            if (d_reg.cnt == `PM_DIV_STEPS) begin
                d_next.busy = 1'b0;
                d_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            d_reg <= '0;
        end else if (clk_en) begin
            d_reg <= d_next;
        end
    end

    assign done     = d_reg.done;
    assign quotient = d_reg.quo;

endmodule
`default_nettype wire

// file: pm_host.sv
// host model driving the register strobe port of the monitor
`timescale 1ns/100ps
`default_nettype none
module pm_host
    import pm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [15:0] rdata,
    output var  pm_req_t     req
);
    // idle port at time zero; stale fields are scrambled after each write strobe
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        req = '{1'b0, 1'b0, ~a, ~d};
        @(negedge mclk);
    endtask
    // data taken one and a half cycles after the strobe edge, so latency is safe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge mclk);
        req = '{1'b0, 1'b1, a, ~req.wdata};
        @(negedge mclk);
        req.rd = 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// file: pm_monitor.sv
// result, calibration and alarm registers of the power monitor
`timescale 1ns/100ps
`default_nettype none
`include "pm_cfg.svh"

// Function
// (RQ1) bus result is unsigned 15 bits, 1.25 mV per count
// (RQ2) top bit of bus result always reads zero
// (RQ3) results hold the averaged value when averaging is selected
// (RQ4) one power count equals 25 current counts
// (RQ5) power is current times bus voltage
// (RQ6) current is shunt voltage times calibration value
// (RQ7) calibration register read/write, 15-bit field in bits 14:0
// (RQ8) only the highest set limit enable in bits 15:11 acts
// (RQ9) bit 15: alarm when shunt result exceeds limit
// (RQ10) bit 14: alarm when shunt result falls below limit
// (RQ11) bit 13: alarm when bus result exceeds limit
// (RQ12) bit 12: alarm when bus result falls below limit
// (RQ13) bit 11: alarm when power result exceeds limit
// (RQ14) bit 10: alarm also follows the conversion done flag
// (RQ15) limit flag bit 4: latch clears on read, else next clean result
// (RQ16) done flag set only after averaging and all arithmetic finish
// (RQ17) single-shot: done flag clears on active config write or mask read
// (RQ18) overflow flag bit 2 marks current and power as suspect
// (RQ19) bit 1 selects alarm polarity, active low by default
// (RQ20) bit 0 selects latch mode, transparent by default
// (RQ21) transparent alarm follows fault, latched alarm holds until read
// (RQ22) 16-bit read/write limit register compared with chosen result
// (RQ23) shunt result is signed 16-bit two's complement
// (RQ24) config write aborts conversion and restarts with new settings
// (RQ25) limits evaluated once per completed averaged result
// (RQ26) mask bits 9:5 read zero; flag bits 4:2 read-only
module pm_monitor
    import pm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire pm_req_t     req,
    input  wire pm_sample_t  sample,
    input  wire pm_cfg_t     cfg,
    output logic [15:0]      rdata,
    output logic             alarm_out,
    output logic             alarm_oe
);

    pm_regs_t r_reg;
    pm_regs_t r_next;

    logic        div_start;
    logic        div_abort;
    logic        div_done;
    logic [30:0] div_quo;
    logic [30:0] div_dividend;
    logic [3:0]  avg_shift;
    logic [10:0] avg_last;
    logic        single_shot;
    logic        cfg_active;
    logic        mask_read;
    logic [25:0] acc_sh_sum;
    logic [24:0] acc_bus_sum;
    logic [25:0] sh_avg;
    logic [24:0] bus_avg;
    logic [31:0] cur_prod;
    logic [31:0] cur_scaled;
    logic        cur_ovf;
    logic [15:0] cur_mag;
    logic        limit_hit;
    logic        func_en;
    logic        alarm_act;

    // averaging counts are all powers of two, so a shift divides
    always_comb begin
        case (cfg.avg)
            3'd0:    avg_shift = 4'd0;
            3'd1:    avg_shift = 4'd2;
            3'd2:    avg_shift = 4'd4;
            3'd3:    avg_shift = 4'd6;
            3'd4:    avg_shift = 4'd7;
            3'd5:    avg_shift = 4'd8;
            3'd6:    avg_shift = 4'd9;
            default: avg_shift = 4'd10;
        endcase
    end

    // config decode and register port side effects
    assign avg_last    = 11'((12'h001 << avg_shift) - 12'h001);
    assign single_shot = ~cfg.mode[2];
    assign cfg_active  = cfg.mode[1:0] != 2'b00;
    assign mask_read   = req.rd && (req.addr == `PM_OFS_MASK);

    // running sums; shunt is sign extended before adding
    assign acc_sh_sum  = r_reg.acc_sh + {{10{sample.shunt[15]}}, sample.shunt};
    assign acc_bus_sum = r_reg.acc_bus + {10'h000, sample.bus};
    assign sh_avg      = $signed(acc_sh_sum) >>> avg_shift; // [RQ3] [RQ23]
    assign bus_avg     = acc_bus_sum >> avg_shift; // [RQ3]

    // current = shunt * calibration, scaled down to the current lsb
    // operands widened first so the product keeps all 32 bits
    assign cur_prod   = $signed({{16{r_reg.sh_res[15]}}, r_reg.sh_res})
                      * $signed({17'h00000, r_reg.cal});
    assign cur_scaled = $signed(cur_prod) >>> `PM_CURRENT_SHIFT; // [RQ6]
    assign cur_ovf    = (cur_scaled[31:15] != {17{cur_scaled[15]}});

    // power uses the current magnitude since the power result is unsigned
    assign cur_mag = r_reg.cur_res[15] ? 16'(-r_reg.cur_res) : r_reg.cur_res;
    assign div_dividend = {15'h0000, cur_mag}
                        * {16'h0000, r_reg.bus_res[14:0]}; // [RQ5]
    assign div_start = (r_reg.state == PM_ST_PWR_GO);
    assign div_abort = cfg.wr; // [RQ24]

    // highest numbered enable wins; lower ones are not looked at
    always_comb begin
        func_en   = 1'b1;
        limit_hit = 1'b0;
        if (r_reg.en[5]) begin // [RQ8]
            limit_hit = $signed(r_reg.sh_res) > $signed(r_reg.limit); // [RQ9]
        end else if (r_reg.en[4]) begin
            limit_hit = $signed(r_reg.sh_res) < $signed(r_reg.limit); // [RQ10]
        end else if (r_reg.en[3]) begin
            limit_hit = r_reg.bus_res > r_reg.limit; // [RQ11]
        end else if (r_reg.en[2]) begin
            limit_hit = r_reg.bus_res < r_reg.limit; // [RQ12]
        end else if (r_reg.en[1]) begin
            limit_hit = r_reg.pwr_res > r_reg.limit; // [RQ13]
        end else begin
            func_en = 1'b0;
        end
    end

    // next state of everything
    always_comb begin
        r_next = r_reg;
        r_next.alarm_out = 1'b0; // open collector only ever pulls low

        // host reads: data is held until the next read
        if (req.rd) begin
            if (req.addr == `PM_OFS_BUS) begin
                r_next.rdata = {1'b0, r_reg.bus_res[14:0]}; // [RQ1] [RQ2]
            end else if (req.addr == `PM_OFS_PWR) begin
                r_next.rdata = r_reg.pwr_res;
            end else if (req.addr == `PM_OFS_CUR) begin
                r_next.rdata = r_reg.cur_res;
            end else if (req.addr == `PM_OFS_CAL) begin
                r_next.rdata = {1'b0, r_reg.cal}; // [RQ7]
            end else if (req.addr == `PM_OFS_MASK) begin
                r_next.rdata = {r_reg.en, 5'h00, r_reg.aff, r_reg.conversion_done_flag,
                                r_reg.ovf, r_reg.alarm_level_invert, r_reg.len}; // [RQ26]
            end else if (req.addr == `PM_OFS_LIMIT) begin
                r_next.rdata = r_reg.limit; // [RQ22]
            end else begin
                r_next.rdata = `PM_RST_WORD;
            end
        end

        // host writes; flag bits are not writable
        if (req.wr) begin
            if (req.addr == `PM_OFS_CAL) begin
                r_next.cal = req.wdata[14:0]; // [RQ7]
            end else if (req.addr == `PM_OFS_MASK) begin
                r_next.en   = req.wdata[15:10]; // [RQ26]
                r_next.alarm_level_invert = req.wdata[`PM_B_LVL_INV]; // [RQ19]
                r_next.len  = req.wdata[`PM_B_HOLD_EN]; // [RQ20]
            end else if (req.addr == `PM_OFS_LIMIT) begin
                r_next.limit = req.wdata; // [RQ22]
            end
        end

        // clears first, so a set in the same cycle wins below
        if (mask_read) begin
            r_next.conversion_done_flag = 1'b0; // [RQ17]
            if (r_reg.len) begin
                r_next.aff = 1'b0; // [RQ15] [RQ21]
            end
        end
        if (cfg.wr && single_shot && cfg_active) begin
            r_next.conversion_done_flag = 1'b0; // [RQ17]
        end

        // conversion sequence
        case (r_reg.state)
            PM_ST_ACC: begin
                if (sample.valid) begin
                    r_next.acc_sh  = acc_sh_sum;
                    r_next.acc_bus = acc_bus_sum;
                    r_next.cnt     = r_reg.cnt + 11'd1;
                    if (r_reg.cnt == avg_last) begin
                        r_next.sh_res  = sh_avg[15:0]; // [RQ3] [RQ23]
                        r_next.bus_res = {1'b0, bus_avg[14:0]}; // [RQ1] [RQ2]
                        r_next.acc_sh  = '0;
                        r_next.acc_bus = '0;
                        r_next.cnt     = 11'd0;
                        r_next.state   = PM_ST_CUR;
                    end
                end
            end
            PM_ST_CUR: begin
                // saturate rather than wrap so software sees the right sign
                if (cur_ovf) begin
                    r_next.cur_res = cur_scaled[31] ? 16'h8000 : 16'h7fff;
                end else begin
                    r_next.cur_res = cur_scaled[15:0]; // [RQ6]
                end
                r_next.ovf   = cur_ovf; // [RQ18]
                r_next.state = PM_ST_PWR_GO;
            end
            PM_ST_PWR_GO: begin
                r_next.state = PM_ST_PWR_WAIT;
            end
            PM_ST_PWR_WAIT: begin
                if (div_done) begin
                    if (div_quo[30:16] != 15'h0000) begin
                        r_next.pwr_res = 16'hffff;
                        r_next.ovf     = 1'b1; // [RQ18]
                    end else begin
                        r_next.pwr_res = div_quo[15:0]; // [RQ4] [RQ5]
                    end
                    r_next.state = PM_ST_EVAL;
                end
            end
            PM_ST_EVAL: begin
                // all results final: compare once, then flag completion
                if (r_reg.len) begin
                    if (func_en && limit_hit) begin
                        r_next.aff = 1'b1; // [RQ15] [RQ25]
                    end
                end else begin
                    r_next.aff = func_en && limit_hit; // [RQ15] [RQ21]
                end
                r_next.conversion_done_flag  = 1'b1; // [RQ16]
                r_next.state = PM_ST_ACC;
            end
            default: begin
                r_next.state = PM_ST_ACC;
            end
        endcase

        // new settings restart the sequence from an empty average
        if (cfg.wr) begin
            r_next.state   = PM_ST_ACC; // [RQ24]
            r_next.acc_sh  = '0;
            r_next.acc_bus = '0;
            r_next.cnt     = 11'd0;
        end

        // pin pulls low when active and normal, or idle and inverted
        // alarm source: selected limit function or, if enabled, done flag
        alarm_act = (func_en && r_next.aff)
                  || (r_next.en[0] && r_next.conversion_done_flag); // [RQ14] [RQ21]
        r_next.alarm_oe = alarm_act ^ r_next.alarm_level_invert; // [RQ19]
    end

    pm_divider u_div (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .start    (div_start),
        .abort    (div_abort),
        .dividend (div_dividend),
        .divisor  (15'(`PM_POWER_DIV)),
        .done     (div_done),
        .quotient (div_quo)
    );

    // all state held; clock enable freezes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign rdata     = r_reg.rdata;
    assign alarm_out = r_reg.alarm_out;
    assign alarm_oe  = r_reg.alarm_oe;

endmodule
`default_nettype wire

// file: pm_monitor_sva.sv
// assertions on the monitor register port and alarm pin
`timescale 1ns/100ps
`default_nettype none
`include "pm_cfg.svh"
module pm_monitor_sva
    import pm_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire pm_req_t     req,
    input wire logic [15:0] rdata,
    input wire logic        alarm_out,
    input wire logic        alarm_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // accepted strobes and write data kept for readback checks
    logic        rd_ok;
    logic        wr_ok;
    logic [15:0] wd;
    logic [14:0] wd_lo;
    assign rd_ok = clk_en && req.rd;
    assign wr_ok = clk_en && req.wr;
    assign wd = req.wdata;
    assign wd_lo = req.wdata[14:0];
    a_pin_low: assert property (alarm_out == 1'b0)
        else $error("pin value high");
    a_oe_reset_idle: assert property ($rose(rst_n) |-> !alarm_oe)
        else $error("oe set after reset");
    a_rdata_held: assert property (!rd_ok |=> $stable(rdata))
        else $error("rdata moved without read");
    a_bus_msb_zero: assert property (
        rd_ok && req.addr == `PM_OFS_BUS |=> !rdata[15])
        else $error("bus msb set");
    a_mask_gap_zero: assert property (
        rd_ok && req.addr == `PM_OFS_MASK |=> rdata[9:5] == 5'h00)
        else $error("mask gap nonzero");
    a_unmapped_zero: assert property (
        rd_ok && req.addr > `PM_OFS_LIMIT |=> rdata == 16'h0000)
        else $error("unmapped read nonzero");
    a_cal_readback: assert property (
        wr_ok && req.addr == `PM_OFS_CAL ##1 !wr_ok [*2] ##1
        rd_ok && !wr_ok && req.addr == `PM_OFS_CAL
        |=> rdata == {1'b0, $past(wd_lo, 4)})
        else $error("calibration readback wrong");
    a_limit_readback: assert property (
        wr_ok && req.addr == `PM_OFS_LIMIT ##1 !wr_ok [*2] ##1
        rd_ok && !wr_ok && req.addr == `PM_OFS_LIMIT
        |=> rdata == $past(wd, 4))
        else $error("limit readback wrong");
endmodule
bind pm_monitor pm_monitor_sva pm_monitor_sva_inst (.mclk(mclk),
    .rst_n(rst_n), .clk_en(clk_en), .req(req), .rdata(rdata),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe));
`default_nettype wire

// file: pm_pkg.sv
// types shared by the power monitor result and alarm logic
package pm_pkg;

    // host register port request, one strobe per access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pm_req_t;

    // one raw converter sample pair
    typedef struct packed {
        logic        valid;
        logic [15:0] shunt;
        logic [14:0] bus;
    } pm_sample_t;

    // configuration settings seen from outside the block
    typedef struct packed {
        logic       wr;
        logic [2:0] mode;
        logic [2:0] avg;
    } pm_cfg_t;

    typedef enum logic [2:0] {
        PM_ST_ACC,
        PM_ST_CUR,
        PM_ST_PWR_GO,
        PM_ST_PWR_WAIT,
        PM_ST_EVAL
    } pm_state_t;

    // divider state
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [4:0]  cnt;
        logic [15:0] rem;
        logic [30:0] quo;
    } pm_div_t;

    // whole state of the monitor
    typedef struct packed {
        pm_state_t   state;
        logic [10:0] cnt;
        logic [25:0] acc_sh;
        logic [24:0] acc_bus;
        logic [15:0] sh_res;
        logic [15:0] bus_res;
        logic [15:0] cur_res;
        logic [15:0] pwr_res;
        logic [14:0] cal;
        logic [5:0]  en;
        logic        aff;
        logic        conversion_done_flag;
        logic        ovf;
        logic        alarm_level_invert;
        logic        len;
        logic [15:0] limit;
        logic [15:0] rdata;
        logic        alarm_oe;
        logic        alarm_out;
    } pm_regs_t;

endpackage

// file: tb_power_monitor_results_and_alert.sv
// self-checking bench for the monitor result and alarm registers
`timescale 1ns/100ps
`default_nettype none
module tb_power_monitor_results_and_alert
    import pm_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    pm_req_t     req;
    pm_sample_t  sample = '0;
    pm_cfg_t     cfg = '{1'b0, 3'b111, 3'd0};
    logic [15:0] rdata;
    logic        alarm_out;
    logic        alarm_oe;
    int          failures = 0;
    int          n_checks = 0;
    // 20 ns clock
    always #10 mclk = ~mclk;
    pm_monitor pm_monitor_inst (.mclk(mclk), .rst_n(rst_n),
        .clk_en(clk_en), .req(req), .sample(sample), .cfg(cfg),
        .rdata(rdata), .alarm_out(alarm_out), .alarm_oe(alarm_oe));
    pm_host pm_host_inst (.mclk(mclk), .rdata(rdata), .req(req));
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        pm_host_inst.wr(a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        pm_host_inst.rd(a, d);
        chk16(d, e);
    endtask
    task automatic cv(input logic [15:0] s, input logic [14:0] b, int g);
        @(negedge mclk);
        sample = '{1'b1, s, b};
        @(negedge mclk);
        sample = '{1'b0, ~s, ~b};
        repeat (g) @(negedge mclk);
    endtask
    task automatic t_regs;
        for (int a = 2; a < 9; a++) begin
            rc(8'(a), 16'h0000);
        end
        wr(8'h05, 16'hffff);
        rc(8'h05, 16'h7fff);
        wr(8'h07, 16'ha5c3);
        rc(8'h07, 16'ha5c3);
        wr(8'h06, 16'hfffc);
        rc(8'h06, 16'hfc00);
    endtask
    task automatic t_alarm;
        wr(8'h05, 16'h0800);
        wr(8'h07, 16'h0100);
        wr(8'h06, 16'h2000);
        cv(16'h00c8, 15'h0320, 45);
        rc(8'h02, 16'h0320);
        rc(8'h04, 16'h00c8);
        rc(8'h03, 16'h0008);
        chk1(alarm_oe, 1'b1);
        rc(8'h06, 16'h2018);
        cv(16'h00c8, 15'h0080, 45);
        chk1(alarm_oe, 1'b0);
        rc(8'h06, 16'h2008);
        wr(8'h06, 16'h1001);
        cv(16'h00c8, 15'h0080, 45);
        cv(16'h00c8, 15'h0320, 45);
        chk1(alarm_oe, 1'b1);
        rc(8'h06, 16'h1019);
        chk1(alarm_oe, 1'b0);
    endtask
    task automatic t_limits;
        wr(8'h06, 16'ha002);
        cv(16'h0010, 15'h0320, 45);
        chk1(alarm_oe, 1'b1);
        cv(16'h0200, 15'h0320, 45);
        chk1(alarm_oe, 1'b0);
        rc(8'h06, 16'ha01a);
        wr(8'h06, 16'h4000);
        cv(16'hff00, 15'h0320, 45);
        chk1(alarm_oe, 1'b1);
        rc(8'h04, 16'hff00);
        rc(8'h03, 16'h000a);
        wr(8'h07, 16'h0005);
        wr(8'h06, 16'h0800);
        cv(16'hff00, 15'h0320, 45);
        chk1(alarm_oe, 1'b1);
    endtask
    task automatic t_done;
        wr(8'h05, 16'h7fff);
        wr(8'h06, 16'h0400);
        rc(8'h06, 16'h0418);
        chk1(alarm_oe, 1'b0);
        cv(16'h7fff, 15'h0010, 45);
        chk1(alarm_oe, 1'b1);
        rc(8'h04, 16'h7fff);
        rc(8'h06, 16'h040c);
        chk1(alarm_oe, 1'b0);
    endtask
    task automatic t_avg;
        cfg.avg = 3'd1;
        cv(16'h0010, 15'h7fff, 4);
        cfg.wr = 1'b1;
        @(negedge mclk);
        cfg.wr = 1'b0;
        cv(16'h0010, 15'h0100, 4);
        cv(16'h0010, 15'h0200, 4);
        cv(16'h0010, 15'h0300, 4);
        cv(16'h0010, 15'h0400, 45);
        rc(8'h02, 16'h0280);
        cfg.mode = 3'b011;
        cfg.wr = 1'b1;
        @(negedge mclk);
        cfg.wr = 1'b0;
        rc(8'h06, 16'h0400);
        chk1(alarm_oe, 1'b0);
    endtask
    // reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        t_regs();
        t_alarm();
        t_limits();
        t_done();
        t_avg();
        results();
    end
    // watchdog well past the expected run of under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        results();
    end
    task automatic results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
